// [sim/acp_host_model.sv]
// Host controller model: drives the conversion pins and the parallel port
// Assumes the device samples its pins on mclk_in; pin changes land on falling edges
`timescale 1ns/1ps
module acp_host_model (
	// Clock and device outputs
	input wire logic mclk_in,
	input wire logic busy_in,
	input wire logic [11:0] dev_data_in,
	input wire logic dev_oe_n_in,
	// Host pins
	output logic trig_n_out,
	output logic conv_clk_out,
	output logic cs_n_out,
	output logic rd_n_out,
	output logic wr_n_out,
	output logic [11:0] bus_out
);
	logic drive = 1'b0;
	logic [11:0] drv_val = 12'h000;
	logic [11:0] last = 12'h000;
	initial begin
		trig_n_out = 1'b1;
		conv_clk_out = 1'b0;
		cs_n_out = 1'b1;
		rd_n_out = 1'b1;
		wr_n_out = 1'b1;
	end
	// Released bus toggles on every mclk_in rise, showing the last bus word inverted, then as it was
	assign bus_out = drive ? drv_val : (!dev_oe_n_in ? dev_data_in : ~last);
	always_ff @(posedge mclk_in) last <= bus_out;
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk_in);
	endtask
	// Clock stands still at lvl while the trigger falls
	task automatic start_conv(input logic lvl);
		conv_clk_out = lvl;
		cyc(3);
		trig_n_out = 1'b0;
		cyc(2);
		trig_n_out = 1'b1;
		cyc(4);
		conv_clk_out = 1'b0;
		cyc(4);
	endtask
	task automatic conv_clocks(output int rises);
		rises = 0;
		while (busy_in && rises < 20) begin
			conv_clk_out = 1'b1;
			rises++;
			cyc(4);
			conv_clk_out = 1'b0;
			cyc(4);
		end
	endtask
	task automatic read(input logic sel, output logic [11:0] w, output logic drv);
		cs_n_out = !sel;
		rd_n_out = 1'b0;
		cyc(6);
		w = bus_out;
		drv = !dev_oe_n_in;
		rd_n_out = 1'b1;
		cs_n_out = 1'b1;
		cyc(5);
	endtask
	task automatic write(input logic sel, input logic [11:0] v);
		cs_n_out = !sel;
		drv_val = v;
		drive = 1'b1;
		wr_n_out = 1'b0;
		cyc(4);
		wr_n_out = 1'b1;
		cyc(4);
		drive = 1'b0;
		cs_n_out = 1'b1;
		cyc(2);
	endtask
endmodule

// [sim/adc_parallel_conversion_port_tb_top.sv]
// Testbench of the conversion port: host model on the pins, bench drives core results
// Assumes 40 MHz mclk_in and the latencies of the port's hand-over
`timescale 1ns/1ps
module adc_parallel_conversion_port_tb_top
	import acp_pkg::*;
;
	logic mclk_in, nrst_in, busy, hold, oe_n, ovr, trig_n, cclk, cs_n, rd_n, wr_n, seen;
	logic [11:0] core_a, core_b, dout, cfg, bus, w;
	int error_cnt = 0;
	int n_compared = 0;
	int r;
	acp_port #(.DATA_W(ACP_DATA_W), .FIFO_DEPTH(ACP_FIFO_DEPTH)) dut (
		.mclk_in(mclk_in), .nrst_in(nrst_in), .sample_hold_trigger_n_in(trig_n),
		.conv_clk_in(cclk), .busy_out(busy), .hold_out(hold), .cs_n_in(cs_n),
		.rd_n_in(rd_n), .wr_n_in(wr_n), .data_in(bus), .data_out(dout),
		.data_oe_n_out(oe_n), .core_a_in(core_a), .core_b_in(core_b),
		.cfg_out(cfg), .overrun_out(ovr));
	acp_host_model host (
		.mclk_in(mclk_in), .busy_in(busy), .dev_data_in(dout), .dev_oe_n_in(oe_n),
		.trig_n_out(trig_n), .conv_clk_out(cclk), .cs_n_out(cs_n), .rd_n_out(rd_n),
		.wr_n_out(wr_n), .bus_out(bus));
	initial begin
		mclk_in = 1'b0;
		forever #12.5 mclk_in = ~mclk_in;
	end
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic conv(input logic [11:0] a, input logic [11:0] b, input logic lvl);
		core_a = a;
		core_b = b;
		host.start_conv(lvl);
		chk("busy high", 12'h001, {11'h000, busy});
		chk("hold high", 12'h001, {11'h000, hold});
		host.conv_clocks(r);
		if (r >= 20) begin
			error_cnt++;
			end_of_test();
		end
		chk("clock rises", 12'h00E, r[11:0]);
		chk("busy low", 12'h000, {11'h000, busy});
		chk("hold low", 12'h000, {11'h000, hold});
	endtask
	task automatic rd_chk(input logic sel, input logic [11:0] exp, input logic drv);
		host.read(sel, w, seen);
		chk("bus driven", {11'h000, drv}, {11'h000, seen});
		if (drv) chk("read word", exp, w);
		chk("released", 12'h001, {11'h000, oe_n});
	endtask
	task automatic t_convert_read();
		conv(12'hA5C, 12'h3F1, 1'b0);
		rd_chk(1'b1, 12'hA5C, 1'b1);
		rd_chk(1'b1, 12'h3F1, 1'b1);
		$display("test convert_read done");
	endtask
	task automatic t_clock_high();
		conv(12'h801, 12'h07E, 1'b1);
		rd_chk(1'b1, 12'h801, 1'b1);
		rd_chk(1'b1, 12'h07E, 1'b1);
		$display("test clock_high done");
	endtask
	task automatic t_cs_high();
		conv(12'h123, 12'h456, 1'b0);
		rd_chk(1'b0, 12'h000, 1'b0);
		host.write(1'b0, 12'hFFF);
		chk("cfg kept", ACP_CFG_RESET, cfg);
		rd_chk(1'b1, 12'h123, 1'b1);
		rd_chk(1'b1, 12'h456, 1'b1);
		$display("test cs_high done");
	endtask
	task automatic t_write();
		host.write(1'b1, 12'h8A3);
		chk("cfg word", 12'h8A3, cfg);
		host.write(1'b1, 12'h5C7);
		chk("cfg word", 12'h5C7, cfg);
		$display("test write done");
	endtask
	task automatic t_fifo_fill();
		for (int i = 0; i < 4; i++) conv(12'h100 + 12'(i), 12'hE00 + 12'(i), 1'b0);
		chk("overrun", 12'h000, {11'h000, ovr});
		for (int i = 0; i < 4; i++) begin
			rd_chk(1'b1, 12'h100 + 12'(i), 1'b1);
			rd_chk(1'b1, 12'hE00 + 12'(i), 1'b1);
		end
		rd_chk(1'b1, 12'hE03, 1'b1);
		$display("test fifo_fill done");
	endtask
	// Six conversions (twelve words) against an eight-word FIFO set the sticky flag; a mid-run reset clears all
	task automatic t_overrun();
		for (int i = 0; i < 6; i++) conv(12'h200 + 12'(i), 12'hC00 + 12'(i), 1'b0);
		chk("overrun set", 12'h001, {11'h000, ovr});
		rd_chk(1'b1, 12'h200, 1'b1);
		nrst_in = 1'b0;
		repeat (3) @(negedge mclk_in);
		nrst_in = 1'b1;
		repeat (2) @(negedge mclk_in);
		chk("overrun cleared", 12'h000, {11'h000, ovr});
		chk("busy after reset", 12'h000, {11'h000, busy});
		chk("cfg after reset", ACP_CFG_RESET, cfg);
		rd_chk(1'b1, ACP_RESULT_RESET, 1'b1);
		$display("test overrun_reset done");
	endtask
	initial begin
		nrst_in = 1'b0;
		core_a = 12'h000;
		core_b = 12'h000;
		repeat (3) @(negedge mclk_in);
		nrst_in = 1'b1;
		repeat (2) @(negedge mclk_in);
		t_convert_read();
		t_clock_high();
		t_cs_high();
		t_write();
		t_fifo_fill();
		t_overrun();
		end_of_test();
	end
endmodule

// [verilog/acp_fifo.sv]
// Result FIFO of parameter width and depth with valid and ready on both sides
// Assumes one clock; read data come from a register
`timescale 1ns/1ps
module acp_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic nrst_in,
	// Fill side
	input wire logic wr_valid_in,
	output logic wr_ready_out,
	input wire logic [WIDTH-1:0] wr_data_in,
	// Drain side
	output logic rd_valid_out,
	input wire logic rd_ready_in,
	output logic [WIDTH-1:0] rd_data_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wptr;
	logic [AW-1:0] rptr;
	logic [AW:0] count;
	logic do_wr;
	logic do_rd;

	assign do_wr = wr_valid_in && wr_ready_out;
	assign do_rd = rd_valid_out && rd_ready_in;

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wptr <= '0;
			rptr <= '0;
			count <= '0;
		end else begin
			if (do_wr)
				wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
			if (do_rd)
				rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
			if (do_wr && !do_rd)
				count <= count + 1'b1;
			else if (do_rd && !do_wr)
				count <= count - 1'b1;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (do_wr)
			mem[wptr] <= wr_data_in;
	end

	// Registered head word, refreshed whenever the head pointer moves and a stored word remains
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rd_data_out <= '0;
			rd_valid_out <= 1'b0;
			wr_ready_out <= 1'b0;
		end else begin
			wr_ready_out <= (count + (AW+1)'(do_wr) - (AW+1)'(do_rd)) < (AW+1)'(DEPTH);
			if (!rd_valid_out || do_rd) begin
				if (do_rd)
					rd_valid_out <= 1'b0;
				if ((count - (AW+1)'(do_rd)) != '0 && !(rd_valid_out && !do_rd)) begin
					rd_data_out <= mem[do_rd ? ((rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1) : rptr];
					rd_valid_out <= ((count - (AW+1)'(do_rd)) != '0);
				end
			end
		end
	end
endmodule

// [verilog/acp_pkg.sv]
// Package for the conversion control and parallel port of a dual 12-bit converter
// Assumes one system clock mclk_in at 40 MHz; all pins synchronised inside the block
package acp_pkg;
	localparam int ACP_DATA_W = 12;
	localparam int ACP_FIFO_DEPTH = 8;
	localparam int ACP_CONV_EDGES = 14;
	localparam int ACP_CONV_EDGE_W = 4;
	localparam logic [3:0] ACP_CONV_EDGES_C = 4'hE;
	localparam int ACP_MSB_POS = 11;
	localparam int ACP_LSB_POS = 0;
	localparam logic [11:0] ACP_CFG_RESET = 12'h000;
	localparam logic [11:0] ACP_RESULT_RESET = 12'h000;

	typedef enum logic [1:0] {
		ACP_IDLE,
		ACP_HOLD_WAIT,
		ACP_CONVERTING
	} acp_state_type;

	// Pins of the host side parallel port after synchronisation
	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic wr_n;
	} acp_strobe_type;

	// One result word: channel pair marker plus data
	typedef struct packed {
		logic chan_b;
		logic [11:0] data;
	} acp_result_type;
endpackage

// [verilog/acp_port.sv]
// Conversion control and 12-bit parallel host port of a dual converter
// Assumes pins arrive asynchronously to mclk_in; the conversion clock pin is sampled
// Behaviour
// - The falling edge of sample_hold_trigger_n puts the inputs into hold on the third mclk_in rise after it.
// - Conversion begins on the next rising edge of the conversion clock after that fall.
// - Busy goes high once the inputs are in hold.
// - Busy goes low when the conversion is finished and a result waits.
// - Read and write strobes act only while chip select is low.
// - With chip select high all port inputs are ignored and the data bus is released.
// - Each read strobe fall with chip select low and a result waiting puts the next result on the bus.
// - A write strobe rise with chip select low captures the bus word as configuration.
// - Busy falls just after the fourteenth conversion clock rise counted from the start.
`timescale 1ns/1ps
module acp_port
	import acp_pkg::*;
#(
	parameter int DATA_W = ACP_DATA_W,
	parameter int FIFO_DEPTH = ACP_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic nrst_in,
	// Conversion control pins
	input wire logic sample_hold_trigger_n_in,
	input wire logic conv_clk_in,
	output logic busy_out,
	output logic hold_out,
	// Parallel host port
	input wire logic cs_n_in,
	input wire logic rd_n_in,
	input wire logic wr_n_in,
	input wire logic [DATA_W-1:0] data_in,
	output logic [DATA_W-1:0] data_out,
	output logic data_oe_n_out,
	// Analog core results for channel pair A and B
	input wire logic [DATA_W-1:0] core_a_in,
	input wire logic [DATA_W-1:0] core_b_in,
	// Configuration word and overrun flag
	output logic [DATA_W-1:0] cfg_out,
	output logic overrun_out
);
	logic [1:0] trig_s;
	logic [1:0] cclk_s;
	logic [1:0] cs_s;
	logic [1:0] rd_s;
	logic [1:0] wr_s;
	logic [DATA_W-1:0] din_s1;
	logic [DATA_W-1:0] din_s2;
	logic trig_q;
	logic cclk_q;
	acp_strobe_type pins_q;
	acp_strobe_type pins_now;
	acp_state_type state;
	logic [ACP_CONV_EDGE_W-1:0] edge_cnt;
	logic trig_fall;
	logic cclk_rise;
	logic rd_fall;
	logic wr_rise;
	logic push_b;
	logic [DATA_W-1:0] res_b;
	logic fill_valid;
	logic fill_ready;
	acp_result_type fill_word;
	logic head_valid;
	acp_result_type head_word;
	logic conv_done;

	// Two-stage synchronisers
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			trig_s <= 2'h3;
			cclk_s <= 2'h0;
			cs_s <= 2'h3;
			rd_s <= 2'h3;
			wr_s <= 2'h3;
			din_s1 <= '0;
			din_s2 <= '0;
		end else begin
			trig_s <= {trig_s[0], sample_hold_trigger_n_in};
			cclk_s <= {cclk_s[0], conv_clk_in};
			cs_s <= {cs_s[0], cs_n_in};
			rd_s <= {rd_s[0], rd_n_in};
			wr_s <= {wr_s[0], wr_n_in};
			din_s1 <= data_in;
			din_s2 <= din_s1;
		end
	end

	assign pins_now = '{cs_n: cs_s[1], rd_n: rd_s[1], wr_n: wr_s[1]};

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			trig_q <= 1'b1;
			cclk_q <= 1'b0;
			pins_q <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1};
		end else begin
			trig_q <= trig_s[1];
			cclk_q <= cclk_s[1];
			pins_q <= pins_now;
		end
	end

	assign trig_fall = trig_q && !trig_s[1];
	assign cclk_rise = !cclk_q && cclk_s[1];
	assign rd_fall = !pins_now.cs_n && pins_q.rd_n && !pins_now.rd_n;
	assign wr_rise = !pins_now.cs_n && !pins_q.wr_n && pins_now.wr_n;
	assign conv_done = (state == ACP_CONVERTING) && cclk_rise
		&& (edge_cnt == ACP_CONV_EDGES_C - 4'h1);

	// Conversion sequencer
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state <= ACP_IDLE;
			edge_cnt <= '0;
		end else begin
			case (state)
				ACP_IDLE: begin
					if (trig_fall)
						state <= ACP_HOLD_WAIT;
				end
				ACP_HOLD_WAIT: begin
					if (cclk_rise) begin
						state <= ACP_CONVERTING;
						edge_cnt <= 4'h1;
					end
				end
				ACP_CONVERTING: begin
					if (conv_done)
						state <= ACP_IDLE;
					else if (cclk_rise)
						edge_cnt <= edge_cnt + 4'h1;
				end
				default: state <= ACP_IDLE;
			endcase
		end
	end

	// Hold and busy rise together on the trigger fall and end together with the conversion
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			busy_out <= 1'b0;
			hold_out <= 1'b0;
		end else if (state == ACP_IDLE && trig_fall) begin
			busy_out <= 1'b1;
			hold_out <= 1'b1;
		end else if (conv_done) begin
			busy_out <= 1'b0;
			hold_out <= 1'b0;
		end
	end

	// Push pair A then pair B into the result FIFO
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			fill_valid <= 1'b0;
			fill_word <= '0;
			push_b <= 1'b0;
			res_b <= ACP_RESULT_RESET;
			overrun_out <= 1'b0;
		end else begin
			if (conv_done) begin
				if (fill_valid || push_b)
					overrun_out <= 1'b1;
				fill_valid <= 1'b1;
				fill_word <= '{chan_b: 1'b0, data: core_a_in};
				res_b <= core_b_in;
				push_b <= 1'b1;
			end else if (fill_valid && fill_ready) begin
				if (push_b) begin
					fill_word <= '{chan_b: 1'b1, data: res_b};
					push_b <= 1'b0;
				end else begin
					fill_valid <= 1'b0;
				end
			end
		end
	end

	acp_fifo #(
		.WIDTH(DATA_W + 1),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.mclk_in(mclk_in),
		.nrst_in(nrst_in),
		.wr_valid_in(fill_valid),
		.wr_ready_out(fill_ready),
		.wr_data_in(fill_word),
		.rd_valid_out(head_valid),
		.rd_ready_in(rd_fall),
		.rd_data_out(head_word)
	);

	// Read port: bus released while chip select is high
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			data_out <= ACP_RESULT_RESET;
			data_oe_n_out <= 1'b1;
		end else begin
			data_oe_n_out <= pins_now.cs_n || pins_now.rd_n;
			if (rd_fall && head_valid)
				data_out <= head_word.data;
		end
	end

	// Configuration write
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in)
			cfg_out <= ACP_CFG_RESET;
		else if (wr_rise)
			cfg_out <= din_s2;
	end

	a_busy_rises: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		(state == ACP_IDLE && trig_fall) |=> busy_out && hold_out)
		else $error("busy not raised after trigger fall");
	a_hold_no_clk: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		(state == ACP_IDLE && trig_fall && !cclk_rise) |=> state == ACP_HOLD_WAIT)
		else $error("hold not entered without clock edge");
	a_start_edge: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		(state == ACP_HOLD_WAIT && cclk_rise) |=> state == ACP_CONVERTING && edge_cnt == 4'h1)
		else $error("conversion did not start on clock rise");
	a_busy_falls: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		conv_done |=> !busy_out && state == ACP_IDLE)
		else $error("busy not cleared at end");
	a_busy_14th: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		$fell(busy_out) |-> $past(edge_cnt) == ACP_CONV_EDGES_C - 4'h1)
		else $error("busy fell on wrong clock edge");
	a_cs_high_hiz: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		pins_now.cs_n |=> data_oe_n_out)
		else $error("bus driven with chip select high");
	a_cs_gates: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		pins_now.cs_n |=> $stable(cfg_out))
		else $error("write taken with chip select high");
	a_write_cap: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		wr_rise |=> cfg_out == $past(din_s2))
		else $error("write word not captured");
	a_read_data: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		(rd_fall && head_valid) |=> data_out == $past(head_word.data) && !data_oe_n_out)
		else $error("read did not present result");

	c_conversion: cover property (@(posedge mclk_in) disable iff (!nrst_in) conv_done);
	c_read: cover property (@(posedge mclk_in) disable iff (!nrst_in) rd_fall && head_valid);
	c_write: cover property (@(posedge mclk_in) disable iff (!nrst_in) wr_rise);
	c_overrun: cover property (@(posedge mclk_in) disable iff (!nrst_in) $rose(overrun_out));
endmodule
